// file: rtl/status_params.svh
/*
 * Constants of the primary status register: offset, field positions, reset value.
 * Assumes inclusion by bare name from the package or a design file.
 */
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define STAT_OFFSET 8'h06
`define STAT_RESET 16'h0010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STAT_POISON_BIT 15
`define STAT_SYSFAULT_BIT 14
`define STAT_UR_BIT 13
`define STAT_CA_REC_BIT 12
`define STAT_CA_SIG_BIT 11
`define STAT_MDP_BIT 8
`define STAT_CAP_BIT 4
`define CMD_PERR_BIT 6
`define CMD_SERR_BIT 8

`endif

// file: rtl/status_pkg.sv
/*
 * Types shared by the primary status register files.
 * Assumes nothing beyond the parameter header.
 */
package status_pkg;
	typedef logic [15:0] reg16_t;
	typedef logic [7:0] addr_t;
endpackage : status_pkg

// file: rtl/sticky_flag.sv
/*
 * One sticky event flag with write-one-to-clear.
 * Assumes event and clear are synchronous to clk_i.
 */
`timescale 1ns/1ns
module sticky_flag (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control
	input wire logic set_i,
	input wire logic clr_i,
	// State
	output logic flag_o
);
	// A set in the same cycle as a clear wins so no event is lost.
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule : sticky_flag

// file: rtl/primary_status_reg.sv
/*
 * Primary-side status register of a bridge configuration header.
 * Assumes the command enables come from a neighbouring register and all inputs share clk_i.
 */
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "status_params.svh"
module primary_status_reg #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Register port
	input wire status_pkg::addr_t addr_i,
	input wire status_pkg::reg16_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output status_pkg::reg16_t rdata_o,
	// Command enables
	input wire logic parity_response_enable_i,
	input wire logic system_fault_enable_i,
	// Link events
	input wire logic rx_poisoned_tlp_i,
	input wire logic rx_poisoned_cpl_i,
	input wire logic tx_poisoned_write_i,
	input wire logic tx_err_msg_i,
	input wire logic rx_cpl_ur_i,
	input wire logic rx_cpl_ca_i,
	input wire logic tx_cpl_ca_i,
	// Flag view
	output status_pkg::reg16_t status_o
);
	import status_pkg::*;

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// The decode compares against an eight-bit offset, so any other width is refused.
	if (ADDR_W != $bits(addr_t)) begin : g_bad_addr_w
		$error("ADDR_W must match the width of the address type");
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic hit(input addr_t a);
		hit = (a == `STAT_OFFSET);
	endfunction : hit

	logic wr_hit;
	assign wr_hit = wr_i && hit(addr_i);

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	localparam int NFLAG = 6;
	localparam int FLAG_POS [NFLAG] = '{`STAT_POISON_BIT, `STAT_SYSFAULT_BIT, `STAT_UR_BIT,
		`STAT_CA_REC_BIT, `STAT_CA_SIG_BIT, `STAT_MDP_BIT};
	logic [NFLAG-1:0] ev;
	logic [NFLAG-1:0] fl;

	// A flag placed on a constant field would let software see a stored bit there.
	for (genvar c = 0; c < NFLAG; c++) begin : g_pos_check
		if (FLAG_POS[c] > 15 || FLAG_POS[c] == `STAT_CAP_BIT) begin : g_bad_pos
			$error("sticky flag position outside the error fields");
		end
	end

	assign ev[0] = rx_poisoned_tlp_i;
	assign ev[1] = tx_err_msg_i && system_fault_enable_i;
	assign ev[2] = rx_cpl_ur_i;
	assign ev[3] = rx_cpl_ca_i;
	assign ev[4] = tx_cpl_ca_i;
	assign ev[5] = parity_response_enable_i && (rx_poisoned_cpl_i || tx_poisoned_write_i);

	genvar g;
	generate
		for (g = 0; g < NFLAG; g++) begin : g_flag
			sticky_flag u_flag (
				.clk_i(clk_i),
				.arst_n_i(arst_n_i),
				.set_i(ev[g]),
				.clr_i(wr_hit && wdata_i[FLAG_POS[g]]),
				.flag_o(fl[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Read view
	// ----------------------------------------
	// Constant fields are never stored, so writes to them cannot have any effect.
	reg16_t view;
	always_comb begin
		view = 16'h0000;
		view[`STAT_CAP_BIT] = 1'b1;
		for (int i = 0; i < NFLAG; i++) begin
			view[FLAG_POS[i]] = fl[i];
		end
	end
	assign status_o = view;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i && hit(addr_i)) begin
			rdata_o <= view;
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_clear_write(int b);
		wr_hit && wdata_i[b];
	endsequence

	sequence s_no_clear(int b);
		!(wr_hit && wdata_i[b]);
	endsequence

	sequence s_read_hit;
		rd_i && hit(addr_i);
	endsequence

	sequence s_read_miss;
		rd_i && !hit(addr_i);
	endsequence

	// Two sampled edges in reset, so the check never sees flops before their first reset.
	sequence s_in_reset;
		!arst_n_i ##1 !arst_n_i;
	endsequence

	// ----------------------------------------
	// Flags set on their events
	// ----------------------------------------
	AST_POISON: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		rx_poisoned_tlp_i
		|=> status_o[15])
		else $error("poison flag not set");
	AST_SYSFAULT_SET: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		tx_err_msg_i && system_fault_enable_i
		|=> status_o[14])
		else $error("fault flag not set");
	AST_UR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		rx_cpl_ur_i
		|=> status_o[13])
		else $error("unsupported flag not set");
	AST_CA_REC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		rx_cpl_ca_i
		|=> status_o[12])
		else $error("abort received flag not set");
	AST_CA_SIG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		tx_cpl_ca_i
		|=> status_o[11])
		else $error("abort signaled flag not set");
	AST_MDP_SET: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		parity_response_enable_i && (rx_poisoned_cpl_i || tx_poisoned_write_i)
		|=> status_o[8])
		else $error("data poison flag not set");
	AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(11) ##0 tx_cpl_ca_i
		|=> status_o[11])
		else $error("event lost to a same-cycle clear");
	AST_SET_WINS_MDP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(8) ##0 (parity_response_enable_i && rx_poisoned_cpl_i)
		|=> status_o[8])
		else $error("data poison event lost to a same-cycle clear");

	// ----------------------------------------
	// Flags stay clear without their events
	// ----------------------------------------
	AST_SYSFAULT_GATE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!status_o[14] && !(tx_err_msg_i && system_fault_enable_i)
		|=> !status_o[14])
		else $error("fault flag set without cause");
	AST_MDP_GATE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!status_o[8] && !parity_response_enable_i
		|=> !status_o[8])
		else $error("data poison flag set while disabled");
	AST_QUIET_POISON: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!status_o[15] && !rx_poisoned_tlp_i
		|=> !status_o[15])
		else $error("poison flag set without cause");
	AST_QUIET_UR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!status_o[13] && !rx_cpl_ur_i
		|=> !status_o[13])
		else $error("unsupported flag set without cause");
	AST_QUIET_CA_REC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!status_o[12] && !rx_cpl_ca_i
		|=> !status_o[12])
		else $error("abort received flag set without cause");
	AST_QUIET_CA_SIG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!status_o[11] && !tx_cpl_ca_i
		|=> !status_o[11])
		else $error("abort signaled flag set without cause");
	AST_QUIET_MDP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!status_o[8] && !(parity_response_enable_i && (rx_poisoned_cpl_i || tx_poisoned_write_i))
		|=> !status_o[8])
		else $error("data poison flag set without cause");

	// ----------------------------------------
	// Clearing and holding
	// ----------------------------------------
	AST_CLEAR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(15) and !rx_poisoned_tlp_i
		|=> !status_o[15])
		else $error("flag not cleared");
	AST_CLEAR_SYSFAULT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(14) ##0 !(tx_err_msg_i && system_fault_enable_i)
		|=> !status_o[14])
		else $error("fault flag not cleared");
	AST_CLEAR_UR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(13) ##0 !rx_cpl_ur_i
		|=> !status_o[13])
		else $error("unsupported flag not cleared");
	AST_CLEAR_CA_REC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(12) ##0 !rx_cpl_ca_i
		|=> !status_o[12])
		else $error("abort received flag not cleared");
	AST_CLEAR_CA_SIG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(11) ##0 !tx_cpl_ca_i
		|=> !status_o[11])
		else $error("abort signaled flag not cleared");
	AST_CLEAR_MDP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_clear_write(8) ##0 !(parity_response_enable_i && (rx_poisoned_cpl_i || tx_poisoned_write_i))
		|=> !status_o[8])
		else $error("data poison flag not cleared");
	AST_HOLD_POISON: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_o[15] ##0 s_no_clear(15)
		|=> status_o[15])
		else $error("poison flag lost");
	AST_HOLD_SYSFAULT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_o[14] ##0 s_no_clear(14)
		|=> status_o[14])
		else $error("fault flag lost");
	AST_HOLD_UR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_o[13] ##0 s_no_clear(13)
		|=> status_o[13])
		else $error("unsupported flag lost");
	AST_HOLD_CA_REC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_o[12] ##0 s_no_clear(12)
		|=> status_o[12])
		else $error("abort received flag lost");
	AST_HOLD_CA_SIG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_o[11] ##0 s_no_clear(11)
		|=> status_o[11])
		else $error("abort signaled flag lost");
	AST_HOLD_MDP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		status_o[8] ##0 s_no_clear(8)
		|=> status_o[8])
		else $error("data poison flag lost");
	AST_READ_KEEPS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_read_hit ##0 (status_o[15] && !wr_i)
		|=> status_o[15])
		else $error("read cleared a flag");

	// ----------------------------------------
	// Read port, constant fields and reset
	// ----------------------------------------
	AST_CONST: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(status_o & 16'h06ff)
		== `STAT_RESET)
		else $error("constant fields wrong");
	AST_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_read_hit
		|=> rdata_o == $past(status_o))
		else $error("read data wrong");
	AST_READ_MISS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_read_miss
		|=> rdata_o == 16'h0000)
		else $error("read of another offset returned data");
	AST_READ_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		!rd_i
		|=> rdata_o == 16'h0000)
		else $error("read data stood too long");
	AST_RD_CONST: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		s_read_hit
		|=> (rdata_o & 16'h06ff) == `STAT_RESET)
		else $error("constant fields wrong in read data");
	AST_RESET_VIEW: assert property (@(posedge clk_i)
		s_in_reset
		|-> status_o == `STAT_RESET)
		else $error("register view wrong in reset");
	AST_RESET_RDATA: assert property (@(posedge clk_i)
		s_in_reset
		|-> rdata_o == 16'h0000)
		else $error("read data not zero in reset");
endmodule : primary_status_reg

// file: testbench/cfg_host.sv
/* Partner model: requester of configuration cycles on the register port.
   Assumes one clock and a slave that never stalls. */
`timescale 1ns/1ns
module cfg_host (
	// Bus
	input wire logic clk_i,
	input wire status_pkg::reg16_t rdata_i,
	output status_pkg::addr_t addr_o,
	output status_pkg::reg16_t wdata_o,
	output logic wr_o,
	output logic rd_o
);
	import status_pkg::*;
	initial begin
		addr_o = 8'h00;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr(input addr_t a, input reg16_t d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// Released data is inverted so a stale value cannot pass.
		wdata_o <= ~d;
	endtask : wr
	task automatic rd(input addr_t a, output reg16_t d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(negedge clk_i);
		d = rdata_i;
	endtask : rd
endmodule : cfg_host

// file: testbench/tb_top.sv
/* Self-checking bench of the primary status register.
   Assumes the design files and the partner model are compiled first. */
`timescale 1ns/1ns
module tb_top;
	import status_pkg::*;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic parity_en = 1'b0;
	logic fault_en = 1'b0;
	logic [6:0] ev = 7'h00;
	logic [6:0] e;
	addr_t addr;
	reg16_t wdata, rdata, status, got;
	logic wr, rd;
	int seed = 32'ha34c;
	int miscompares = 0;
	int samples_checked = 0;
	always #50 clk_i = ~clk_i;
	cfg_host i_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd));
	primary_status_reg i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.parity_response_enable_i(parity_en), .system_fault_enable_i(fault_en),
		.rx_poisoned_tlp_i(ev[0]), .rx_poisoned_cpl_i(ev[1]), .tx_poisoned_write_i(ev[2]),
		.tx_err_msg_i(ev[3]), .rx_cpl_ur_i(ev[4]), .rx_cpl_ca_i(ev[5]),
		.tx_cpl_ca_i(ev[6]), .status_o(status));
	function automatic reg16_t want(input logic [6:0] x, input logic p, input logic s);
		return {x[0], x[3] & s, x[4], x[5], x[6], 2'b00, p & (x[1] | x[2]), 8'h10};
	endfunction : want
	task automatic chk(input string n, input reg16_t x, input reg16_t g);
		samples_checked++;
		if (g !== x) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic pulse(input logic [6:0] x);
		@(posedge clk_i);
		ev <= x;
		@(posedge clk_i);
		ev <= 7'h00;
	endtask : pulse
	task automatic final_report();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(negedge clk_i);
		chk("reset view", 16'h0010, status);
		chk("reset read", 16'h0000, rdata);
		for (int i = 0; i < 24; i++) begin
			// The first two passes raise every event, with enables low and then high.
			e = (i < 2) ? 7'h7f : 7'($random(seed));
			@(posedge clk_i);
			parity_en <= (i < 2) ? i[0] : 1'($random(seed));
			fault_en <= (i < 2) ? i[0] : 1'($random(seed));
			fork
				i_host.wr(8'h06, 16'hffff);
				pulse(e);
			join
			i_host.wr(8'h06, 16'h0000);
			i_host.wr(8'h04, 16'hffff);
			i_host.rd(8'h06, got);
			chk("read", want(e, parity_en, fault_en), got);
			chk("view", want(e, parity_en, fault_en), status);
			@(negedge clk_i);
			chk("read idle", 16'h0000, rdata);
			$display("test %0d done", i);
		end
		i_host.wr(8'h06, 16'hffff);
		i_host.rd(8'h06, got);
		chk("cleared", 16'h0010, got);
		i_host.rd(8'h04, got);
		chk("unmapped", 16'h0000, got);
		@(posedge clk_i);
		parity_en <= 1'b1;
		fault_en <= 1'b1;
		pulse(7'h7f);
		@(negedge clk_i);
		chk("all set", 16'hf910, status);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(negedge clk_i);
		chk("mid reset", 16'h0010, status);
		i_host.rd(8'h06, got);
		chk("read after reset", 16'h0010, got);
		$display("reset test done");
		final_report();
	end
endmodule : tb_top
